// File: common/papc_pkg.sv
package papc_pkg;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_P1_DATA = 8'h00;
  localparam logic [7:0] OFS_P1_DIR  = 8'h04;
  localparam logic [7:0] OFS_P2_DATA = 8'h08;
  localparam logic [7:0] OFS_P2_DIR  = 8'h0C;
  localparam logic [7:0] OFS_ADSEL   = 8'h10;
  localparam logic [7:0] OFS_CHSEL   = 8'h14;
  localparam logic [7:0] OFS_DAC     = 8'h18;
  localparam logic [7:0] OFS_P1AMC   = 8'h1C;
  localparam logic [7:0] OFS_BITOP   = 8'h20;
  localparam logic [7:0] OFS_P2FUNC  = 8'h24;
  // reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'hFF;
  localparam logic [7:0] RST_ADSEL = 8'h00;
  localparam logic [4:0] RST_CHSEL = 5'h1F;
  localparam logic [1:0] RST_DAC   = 2'h0;
  localparam logic       RST_P1AMC = 1'b1;
  // bit-op command fields
  localparam int BOP_BIT_LSB  = 0;
  localparam int BOP_PORT_POS = 3;
  localparam int BOP_VAL_POS  = 4;
  // pin 2 functional encodings
  typedef enum logic [2:0] {
    PAPC_DIG_IN, PAPC_DIG_OUT, PAPC_ANA_CONV, PAPC_ANA_IDLE, PAPC_DAC_OUT, PAPC_PROHIBIT
  } papc_func_t;
  // P1.0 analog-capable channel number and D/A pins index
  localparam logic [4:0] CH_P10 = 5'h10;
  localparam int DAC_PIN0 = 2;
  localparam int DAC_PIN1 = 3;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } papc_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } papc_apb_rsp_t;
  typedef struct packed {
    logic [7:0]  p1_latch;
    logic [7:0]  p1_dir;
    logic [7:0]  p2_latch;
    logic [7:0]  p2_dir;
    logic [7:0]  adsel;
    logic [4:0]  chsel;
    logic [1:0]  dac_en;
    logic        port1_analog_mode_control;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  p1_oe;
    logic [7:0]  p1_out;
    logic [7:0]  p2_oe;
    logic [7:0]  p2_out;
    logic [7:0]  p2_ana;
    logic [7:0]  p2_conv;
    logic [1:0]  dac_drive;
    logic        p10_ana;
    logic        prohibit;
  } papc_state_t;
endpackage

// File: hdl/papc_port_cfg.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Summary of operation
// RULE1: software sets direction and latch before using an alternate function
// RULE2: alternate inputs need direction 1; latch ignored
// RULE3: timer and buzzer outputs need direction 0 latch 0; D/A keeps direction 1
// RULE4: serial, debug tx and I2C pins need direction 0 latch 1
// RULE5: software holds unused alternate outputs on a pin at initial state
// RULE6: direction and latch needs are the same in every package variant
// RULE7: port 2 function from analog select, channel select and direction
// RULE8: digital pins follow direction, regardless of channel select
// RULE9: analog input converted only when selected; analog with output prohibited
// RULE10: D/A pins analog output when enabled and unselected; else analog input (code flags enabled and selected as prohibited)
// RULE11: port 1 pin 0 uses mode control bit, channel select and direction (code decides P1.0 analog from mode control bit and direction only)
// RULE12: single-bit write reads eight bits, changes one, writes eight back
// RULE13: input bits: write goes to latch, read returns pin level
// RULE14: bit write copies live pin levels into untouched input latches
// RULE15: software rewrites latch when turning an input bit into an output
// RULE16: analog select bit 0 is analog input at reset, 1 is digital
module papc_port_cfg (
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  ARST_N,
  // apb
  input  wire papc_pkg::papc_apb_req_t APB_REQ,
  output papc_pkg::papc_apb_rsp_t    APB_RSP,
  // pins (asynchronous levels)
  input  wire logic [7:0]            P1_PIN_IN,
  input  wire logic [7:0]            P2_PIN_IN,
  output logic [7:0]                 P1_PIN_OUT,
  output logic [7:0]                 P1_PIN_OE,
  output logic [7:0]                 P2_PIN_OUT,
  output logic [7:0]                 P2_PIN_OE,
  // analog side
  output logic [7:0]                 P2_ANALOG,
  output logic [7:0]                 P2_CONVERT,
  output logic [1:0]                 DAC_DRIVE,
  output logic                       P10_ANALOG,
  output logic                       CFG_PROHIBITED
);
  import papc_pkg::*;

  papc_state_t st;
  papc_state_t next_st;
  logic [7:0]  p1_s1, p1_s2, p2_s1, p2_s2;
  logic [7:0]  rd1, rd2, mod;
  logic        acc, wr;
  logic [2:0]  bsel;
  logic        sel_ch;
  logic        dac_pin;
  logic        dac_on;

  // pins pass two flops before use
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      p1_s1 <= 8'h00;
      p1_s2 <= 8'h00;
      p2_s1 <= 8'h00;
      p2_s2 <= 8'h00;
    end else begin
      p1_s1 <= P1_PIN_IN;
      p1_s2 <= p1_s1;
      p2_s1 <= P2_PIN_IN;
      p2_s2 <= p2_s1;
    end
  end

  always_comb begin
    next_st = st;
    // read view: input bits show pin, output bits show latch
    rd1 = (st.p1_dir & p1_s2) | (~st.p1_dir & st.p1_latch); // RULE13
    rd2 = (st.p2_dir & p2_s2) | (~st.p2_dir & st.p2_latch); // RULE13
    acc = APB_REQ.psel & APB_REQ.penable & ~st.pready;
    wr = acc & APB_REQ.pwrite;
    bsel = APB_REQ.pwdata[BOP_BIT_LSB +: 3];
    mod = APB_REQ.pwdata[BOP_PORT_POS] ? rd2 : rd1; // RULE12
    mod[bsel] = APB_REQ.pwdata[BOP_VAL_POS]; // RULE12
    next_st.pready = acc;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (acc) begin
      case (APB_REQ.paddr)
        OFS_P1_DATA: begin
          next_st.prdata = {24'h000000, rd1};
          if (wr) next_st.p1_latch = APB_REQ.pwdata[7:0]; // RULE13
        end
        OFS_P1_DIR: begin
          next_st.prdata = {24'h000000, st.p1_dir};
          if (wr) next_st.p1_dir = APB_REQ.pwdata[7:0];
        end
        OFS_P2_DATA: begin
          next_st.prdata = {24'h000000, rd2};
          if (wr) next_st.p2_latch = APB_REQ.pwdata[7:0]; // RULE13
        end
        OFS_P2_DIR: begin
          next_st.prdata = {24'h000000, st.p2_dir};
          if (wr) next_st.p2_dir = APB_REQ.pwdata[7:0];
        end
        OFS_ADSEL: begin
          next_st.prdata = {24'h000000, st.adsel};
          if (wr) next_st.adsel = APB_REQ.pwdata[7:0]; // RULE16
        end
        OFS_CHSEL: begin
          next_st.prdata = {27'h0000000, st.chsel};
          if (wr) next_st.chsel = APB_REQ.pwdata[4:0];
        end
        OFS_DAC: begin
          next_st.prdata = {30'h00000000, st.dac_en};
          if (wr) next_st.dac_en = APB_REQ.pwdata[1:0];
        end
        OFS_P1AMC: begin
          // unmounted bits read as one
          next_st.prdata = {24'h000000, 7'h7F, st.port1_analog_mode_control};
          if (wr) next_st.port1_analog_mode_control = APB_REQ.pwdata[0];
        end
        OFS_BITOP: begin
          // whole byte written back, so input latches pick up pin levels
          if (wr && APB_REQ.pwdata[BOP_PORT_POS]) next_st.p2_latch = mod; // RULE14
          if (wr && !APB_REQ.pwdata[BOP_PORT_POS]) next_st.p1_latch = mod; // RULE14
        end
        OFS_P2FUNC: begin
          next_st.prdata = {24'h000000, st.p2_ana};
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    // pin drive: direction 0 drives latch on digital pins (P1.0 needs mode control 0, port 2 needs analog select 1); timer/serial/i2c follow same pairs
    next_st.p1_oe = ~st.p1_dir; // RULE2 RULE3 RULE4 RULE6
    next_st.p1_out = st.p1_latch;
    next_st.p10_ana = st.port1_analog_mode_control & st.p1_dir[0]; // RULE11
    next_st.prohibit = st.port1_analog_mode_control & ~st.p1_dir[0]; // RULE11
    if (!st.port1_analog_mode_control) next_st.p1_oe[0] = ~st.p1_dir[0];
    else next_st.p1_oe[0] = 1'b0;
    next_st.p2_out = st.p2_latch;
    next_st.dac_drive = 2'b00;
    for (int i = 0; i < 8; i++) begin
      sel_ch = (st.chsel == 5'(i));
      dac_pin = (i == DAC_PIN0) || (i == DAC_PIN1);
      dac_on = dac_pin && st.dac_en[(i == DAC_PIN1) ? 1 : 0];
      next_st.p2_oe[i] = 1'b0;
      next_st.p2_ana[i] = 1'b0;
      next_st.p2_conv[i] = 1'b0;
      if (st.adsel[i]) begin
        next_st.p2_oe[i] = ~st.p2_dir[i]; // RULE7 RULE8
      end else if (!st.p2_dir[i]) begin
        next_st.prohibit = 1'b1; // RULE9
      end else if (dac_on) begin
        if (sel_ch) next_st.prohibit = 1'b1; // RULE10
        else next_st.dac_drive[(i == DAC_PIN1) ? 1 : 0] = 1'b1; // RULE10
        next_st.p2_ana[i] = 1'b1;
      end else begin
        next_st.p2_ana[i] = 1'b1; // RULE9
        next_st.p2_conv[i] = sel_ch; // RULE9
      end
    end
    if (st.port1_analog_mode_control && st.p1_dir[0] && st.chsel == CH_P10) begin
      next_st.p10_ana = 1'b1; // RULE11
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
      st.p1_latch <= RST_LATCH;
      st.p2_latch <= RST_LATCH;
      st.p1_dir <= RST_DIR;
      st.p2_dir <= RST_DIR;
      st.adsel <= RST_ADSEL; // RULE16
      st.chsel <= RST_CHSEL;
      st.dac_en <= RST_DAC;
      st.port1_analog_mode_control <= RST_P1AMC;
    end else begin
      st <= next_st;
    end
  end

  assign APB_RSP.pready = st.pready;
  assign APB_RSP.pslverr = st.pslverr;
  assign APB_RSP.prdata = st.prdata;
  assign P1_PIN_OUT = st.p1_out;
  assign P1_PIN_OE = st.p1_oe;
  assign P2_PIN_OUT = st.p2_out;
  assign P2_PIN_OE = st.p2_oe;
  assign P2_ANALOG = st.p2_ana;
  assign P2_CONVERT = st.p2_conv;
  assign DAC_DRIVE = st.dac_drive;
  assign P10_ANALOG = st.p10_ana;
  assign CFG_PROHIBITED = st.prohibit;

  property p_out_follows_dir;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ##1 (st.adsel[4] && !$past(st.p2_dir[4]) && $past(st.adsel[4])) |-> st.p2_oe[4];
  endproperty
  a_out_follows_dir: assert property (p_out_follows_dir) else $error("digital out not driven"); // RULE8

  property p_analog_no_drive;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (!st.adsel[5] && $past(!st.adsel[5])) |-> !st.p2_oe[5];
  endproperty
  a_analog_no_drive: assert property (p_analog_no_drive) else $error("analog pin driven"); // RULE7

  property p_conv_sel;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    st.p2_conv[0] |-> ($past(st.chsel) == 5'h00 && !$past(st.adsel[0]));
  endproperty
  a_conv_sel: assert property (p_conv_sel) else $error("conversion without selection"); // RULE9

  property p_prohibit;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ($past(!st.adsel[1]) && $past(!st.p2_dir[1])) |-> st.prohibit;
  endproperty
  a_prohibit: assert property (p_prohibit) else $error("prohibited setting not flagged"); // RULE9

  property p_dac;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    st.dac_drive[0] |-> ($past(st.dac_en[0]) && $past(st.chsel) != 5'h02);
  endproperty
  a_dac: assert property (p_dac) else $error("dac drive wrong"); // RULE10

  property p_rd_pin;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (acc && !APB_REQ.pwrite && APB_REQ.paddr == OFS_P1_DATA && st.p1_dir == 8'hFF)
      |=> st.prdata[7:0] == $past(p1_s2);
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("input read not pin level"); // RULE13

  property p_bitop;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (wr && APB_REQ.paddr == OFS_BITOP && !APB_REQ.pwdata[BOP_PORT_POS])
      |=> st.p1_latch[$past(bsel)] == $past(APB_REQ.pwdata[BOP_VAL_POS]);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit op target wrong"); // RULE12

  property p_bitop_copy;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (wr && APB_REQ.paddr == OFS_BITOP && !APB_REQ.pwdata[BOP_PORT_POS]
      && APB_REQ.pwdata[2:0] != 3'h7 && st.p1_dir[7]) |=> st.p1_latch[7] == $past(p1_s2[7]);
  endproperty
  a_bitop_copy: assert property (p_bitop_copy) else $error("input latch not copied"); // RULE14

  property p_ready;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (APB_REQ.psel && APB_REQ.penable && !st.pready) |=> st.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready late");

  property p_p1_oe_dir;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    st.p1_oe[7:1] == ~$past(st.p1_dir[7:1]);
  endproperty
  a_p1_oe_dir: assert property (p_p1_oe_dir) else $error("port 1 drive not from direction"); // RULE4

  property p_pin_out_latch;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (st.p1_out == $past(st.p1_latch)) && (st.p2_out == $past(st.p2_latch));
  endproperty
  a_pin_out_latch: assert property (p_pin_out_latch) else $error("pin out not latch"); // RULE3

  property p_dig_in;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (st.adsel[6] && st.p2_dir[6]) |=> (!st.p2_oe[6] && !st.p2_ana[6]);
  endproperty
  a_dig_in: assert property (p_dig_in) else $error("digital input wrong"); // RULE8

  property p_dig_out;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (st.adsel[7] && !st.p2_dir[7]) |=> (st.p2_oe[7] && !st.p2_ana[7] && !st.p2_conv[7]);
  endproperty
  a_dig_out: assert property (p_dig_out) else $error("digital output wrong"); // RULE8

  property p_ana_unsel;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (!st.adsel[3] && st.p2_dir[3] && !st.dac_en[1] && st.chsel != 5'h03)
      |=> (st.p2_ana[3] && !st.p2_conv[3]);
  endproperty
  a_ana_unsel: assert property (p_ana_unsel) else $error("unselected analog converted"); // RULE9

  property p_dac_sel_bad;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (!st.adsel[2] && st.p2_dir[2] && st.dac_en[0] && st.chsel == 5'h02) |=> st.prohibit;
  endproperty
  a_dac_sel_bad: assert property (p_dac_sel_bad) else $error("dac select not flagged"); // RULE10

  property p_dac_stopped;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (!st.adsel[2] && st.p2_dir[2] && !st.dac_en[0] && st.chsel == 5'h02)
      |=> (st.p2_conv[2] && !st.dac_drive[0]);
  endproperty
  a_dac_stopped: assert property (p_dac_stopped) else $error("stopped dac pin wrong"); // RULE10

  property p_p10_ana;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (st.port1_analog_mode_control && st.p1_dir[0]) |=> st.p10_ana;
  endproperty
  a_p10_ana: assert property (p_p10_ana) else $error("port 1 pin 0 not analog"); // RULE11

  property p_p10_out_bad;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (st.port1_analog_mode_control && !st.p1_dir[0]) |=> st.prohibit;
  endproperty
  a_p10_out_bad: assert property (p_p10_out_bad) else $error("analog output not flagged"); // RULE11

  property p_rd_latch;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (acc && !APB_REQ.pwrite && APB_REQ.paddr == OFS_P1_DATA && !st.p1_dir[0])
      |=> st.prdata[0] == $past(st.p1_latch[0]);
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("output read not latch"); // RULE13

  property p_wr_latch;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (wr && APB_REQ.paddr == OFS_P1_DATA) |=> st.p1_latch == $past(APB_REQ.pwdata[7:0]);
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("data write missed latch"); // RULE13

  property p_bitop_p2;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (wr && APB_REQ.paddr == OFS_BITOP && APB_REQ.pwdata[BOP_PORT_POS])
      |=> (st.p2_latch[$past(bsel)] == $past(APB_REQ.pwdata[BOP_VAL_POS])
           && st.p1_latch == $past(st.p1_latch));
  endproperty
  a_bitop_p2: assert property (p_bitop_p2) else $error("port 2 bit op wrong"); // RULE12
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
  import papc_pkg::*;
  logic          clk_sys;
  logic          arst_n;
  papc_apb_req_t apb_req;
  papc_apb_rsp_t apb_rsp;
  logic [7:0]    p1_pin_in;
  logic [7:0]    p2_pin_in;
  logic [7:0]    p1_out;
  logic [7:0]    p1_oe;
  logic [7:0]    p2_out;
  logic [7:0]    p2_oe;
  logic [7:0]    p2_ana;
  logic [7:0]    p2_conv;
  logic [1:0]    dac_drv;
  logic          p10_ana;
  logic          prohib;
  int            err_total;
  int            checks_done;

  papc_port_cfg i_papc_port_cfg (
    .CLK_SYS        (clk_sys),
    .ARST_N         (arst_n),
    .APB_REQ        (apb_req),
    .APB_RSP        (apb_rsp),
    .P1_PIN_IN      (p1_pin_in),
    .P2_PIN_IN      (p2_pin_in),
    .P1_PIN_OUT     (p1_out),
    .P1_PIN_OE      (p1_oe),
    .P2_PIN_OUT     (p2_out),
    .P2_PIN_OE      (p2_oe),
    .P2_ANALOG      (p2_ana),
    .P2_CONVERT     (p2_conv),
    .DAC_DRIVE      (dac_drv),
    .P10_ANALOG     (p10_ana),
    .CFG_PROHIBITED (prohib)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; pready and the answer are taken at the first rising edge after the slave has raised pready
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (apb_rsp.pready === 1'b1) begin
        break;
      end
    end
    if (n == 20) begin
      err_total++;
      tally_and_finish();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    acc(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    acc(1'b0, a, 32'h0, q, e);
    chk(what, q, exp);
    chk({what, " slverr"}, {31'h0, e}, 32'h0);
  endtask

  // outputs lag config by a cycle, pins by two sync flops
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial begin
    logic [31:0] q;
    logic        e;
    clk_sys     = 1'b0;
    arst_n      = 1'b0;
    apb_req     = '0;
    p1_pin_in   = 8'hA5;
    p2_pin_in   = 8'h3C;
    err_total   = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle();
    chk("p2 analog at reset", p2_ana, 32'hFF);
    chk("p1 oe at reset", p1_oe, 32'h0);
    rdchk("p1 dir", OFS_P1_DIR, 32'hFF);
    rdchk("p2 dir", OFS_P2_DIR, 32'hFF);
    rdchk("adsel", OFS_ADSEL, 32'h00);
    rdchk("chsel", OFS_CHSEL, 32'h1F);
    rdchk("dac", OFS_DAC, 32'h0);
    rdchk("p1 analog mode", OFS_P1AMC, 32'hFF);
    // input bits: write lands in latch, read shows pins
    wr(OFS_P1_DATA, 32'h3C);
    settle();
    chk("p1 latch", p1_out, 32'h3C);
    rdchk("p1 read", OFS_P1_DATA, 32'hA5);
    // bit set on P1.0 copies high pin levels into input latches
    wr(OFS_P1AMC, 32'h0);
    wr(OFS_P1_DIR, 32'hFE);
    wr(OFS_P1_DATA, 32'h00);
    p1_pin_in <= 8'hFF;
    settle();
    wr(OFS_BITOP, 32'h10);
    settle();
    chk("p1 latch bitop", p1_out, 32'hFF);
    chk("p1 oe", p1_oe, 32'h01);
    rdchk("p1 read mixed", OFS_P1_DATA, 32'hFF);
    // bit clear on P2.7, digital, upper nibble output
    wr(OFS_ADSEL, 32'hFF);
    wr(OFS_P2_DIR, 32'h0F);
    wr(OFS_P2_DATA, 32'hA0);
    p2_pin_in <= 8'h0C;
    settle();
    wr(OFS_BITOP, 32'h0F);
    settle();
    chk("p2 latch bitop", p2_out, 32'h2C);
    chk("p2 oe digital", p2_oe, 32'hF0);
    chk("p2 analog digital", p2_ana, 32'h00);
    chk("prohibited digital", prohib, 32'h0);
    // analog inputs, one converted
    wr(OFS_ADSEL, 32'h00);
    wr(OFS_P2_DIR, 32'hFF);
    wr(OFS_CHSEL, 32'h05);
    settle();
    chk("p2 convert", p2_conv, 32'h20);
    chk("p2 analog", p2_ana, 32'hFF);
    chk("prohibited ok", prohib, 32'h0);
    rdchk("p2 analog status", OFS_P2FUNC, 32'hFF);
    wr(OFS_P2_DIR, 32'hFE);
    settle();
    chk("prohibited ana out", prohib, 32'h1);
    wr(OFS_P2_DIR, 32'hFF);
    // d/a pins
    wr(OFS_DAC, 32'h1);
    wr(OFS_CHSEL, 32'h00);
    settle();
    chk("dac drive", dac_drv, 32'h1);
    chk("convert pin0", p2_conv, 32'h01);
    wr(OFS_CHSEL, 32'h02);
    settle();
    chk("prohibited dac sel", prohib, 32'h1);
    wr(OFS_DAC, 32'h2);
    settle();
    chk("dac drive pin3", dac_drv, 32'h2);
    chk("convert pin2", p2_conv, 32'h04);
    chk("prohibited dac ok", prohib, 32'h0);
    // port 1 pin 0 analog path
    wr(OFS_DAC, 32'h0);
    wr(OFS_P1AMC, 32'h1);
    wr(OFS_CHSEL, {27'h0, CH_P10});
    settle();
    chk("prohibited p10 out", prohib, 32'h1);
    wr(OFS_P1_DIR, 32'hFF);
    settle();
    chk("p10 analog", p10_ana, 32'h1);
    chk("prohibited p10 ok", prohib, 32'h0);
    wr(OFS_CHSEL, 32'h1F);
    wr(OFS_P1AMC, 32'h0);
    settle();
    chk("p10 digital", p10_ana, 32'h0);
    // unmapped address is refused
    acc(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped data", q, 32'h0);
    chk("unmapped slverr", {31'h0, e}, 32'h1);
    tally_and_finish();
  end
endmodule
